//--- verilog/mbrc_pkg.sv
// constants and carrier types for the modbus remote control slave
package mbrc_pkg;
   localparam logic [7:0]  FC_READ_HOLD    = 8'h03;
   localparam logic [7:0]  FC_WRITE_COIL   = 8'h05;
   localparam logic [7:0]  FC_EXC_FLAG     = 8'h80;
   localparam logic [7:0]  EXC_BAD_FC      = 8'h01;
   localparam logic [7:0]  EXC_BAD_ADDR    = 8'h02;
   localparam logic [7:0]  EXC_BAD_DATA    = 8'h03;
   localparam logic [7:0]  EXC_CRC         = 8'h05;
   localparam logic [7:0]  EXC_DENIED      = 8'h07;
   localparam logic [7:0]  EXC_LOCAL       = 8'h17;
   localparam logic [15:0] REG_RATED_VOLT  = 16'h0079;
   localparam logic [15:0] REG_CONDITION   = 16'h01f9;
   localparam logic [15:0] COIL_REMOTE     = 16'h0192;
   localparam logic [15:0] COIL_ON         = 16'hff00;
   localparam logic [15:0] COIL_OFF        = 16'h0000;
   localparam logic [15:0] READ_COUNT      = 16'h0002;
   localparam logic [7:0]  READ_BYTES      = 8'h04;
   localparam logic [15:0] TCP_PORT        = 16'd502;
   localparam logic [15:0] PROTO_ID        = 16'h0000;
   localparam logic [15:0] CRC_INIT        = 16'hffff;
   localparam logic [15:0] CRC_POLY        = 16'ha001;
   localparam logic [3:0]  MBAP_LEN        = 4'd6;
   localparam logic [3:0]  RTU_REQ_LEN     = 4'd8;
   localparam logic [3:0]  PDU_REQ_LEN     = 4'd6;
   localparam logic [7:0]  RESET_SLAVE_ID  = 8'h00;
   localparam logic [31:0] RESET_RATED     = 32'h42a00000;
   // location field value meaning remote over this link
   localparam logic [4:0]  LOC_REMOTE_SELF = 5'h03;
   localparam logic [4:0]  LOC_LOCAL       = 5'h00;
   localparam int          LOC_LSB         = 0;
   localparam int          OUT_ON_BIT      = 7;
   localparam int          REG_MODE_LSB    = 9;

   typedef enum logic [3:0] {
      MBRC_IDLE = 4'b0001,
      MBRC_RECV = 4'b0010,
      MBRC_EXEC = 4'b0100,
      MBRC_SEND = 4'b1000
   } mbrc_state_t;

   // byte stream in either direction
   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } mbrc_byte_t;

   // instrument conditions that gate remote control
   typedef struct packed {
      logic allow_remote;
      logic local_lockout;
      logic other_iface_remote;
      logic setup_menu_open;
      logic power_off;
   } mbrc_cond_t;
endpackage : mbrc_pkg

//--- verilog/mbrc_slave.sv
// modbus rtu/tcp slave serving rated voltage, status and remote coil
//
// Overview of operation
// - rated voltage float is read at register 121 with count two
// - read answers carry four bytes, byte count four; rated voltage as ieee754 single float
// - status word is served as two registers at register 505
// - status encodes location, output on and regulation mode, e.g. 0x483
// - coil 0x0192 written ff00 enters remote when nothing inhibits it
// - successful switch echoes request and signals display update
// - coil 0x0192 written 0000 releases remote control
// - never enter remote unaided; control writes refused until granted
// - reads are always served regardless of remote state
// - remote persists until release, lockout, power off or mains loss
// - remote forbidden by setting answers 0x85 with code 0x17
// - front-panel lockout refuses every remote request
// - refuse remote while another interface holds remote
// - refuse remote while setup menu stays open
// - remote ends on release command or on lockout
// - tcp frames carry a six byte mbap header first
// - tcp frames have no crc trailer either way
// - tcp frames accepted only on port 502, others ignored
// - transaction identifier copied unchanged into the answer
// - mbap protocol identifier is always zero
// - mbap length counts bytes following it, equal to core length
// - exception answers return function code plus 0x80
// - rtu crc sent low byte first; wrong crc answers code 0x05
// - coil writes refused by an inhibit condition answer code 0x07
`timescale 1ns/1ps
module mbrc_slave
   import mbrc_pkg::*;
#(
   parameter logic [7:0] SLAVE_ID = RESET_SLAVE_ID
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // request byte stream, tcp_mode and port valid with first byte
   input  wire mbrc_byte_t  rx,
   input  wire logic        tcp_mode,
   input  wire logic [15:0] tcp_port,
   // answer byte stream, one byte per tx_ready
   input  wire logic        tx_ready,
   output mbrc_byte_t       tx,
   // instrument values and conditions
   input  wire logic [31:0] rated_voltage_float,
   input  wire logic        output_on,
   input  wire logic [1:0]  current_regulation_mode,
   input  wire mbrc_cond_t  cond,
   // remote state and display update pulse
   output logic             remote_active,
   output logic             display_update
);
   // receive, answer and remote state in one register
   typedef struct packed {
      mbrc_state_t  st;
      logic [3:0]   cnt;
      logic [7:0][7:0] rxb;
      logic         tcp;
      logic         drop;
      logic [15:0]  crc;
      logic [15:0]  tid;
      logic [3:0]   len;
      logic [3:0]   idx;
      logic [15:0][7:0] txb;
      logic         remote;
      logic         disp;
      mbrc_byte_t   tx;
   } mbrc_reg_t;

   mbrc_reg_t r;
   mbrc_reg_t next_r;

   // request buffer holds eight bytes, counters count to fifteen
   if (RTU_REQ_LEN > 4'd8 || PDU_REQ_LEN > 4'd8) begin : g_req_chk
      $error("request buffer shorter than a request");
   end
   if (int'(MBAP_LEN) + int'(PDU_REQ_LEN) > 15) begin : g_cnt_chk
      $error("frame counter too narrow for a tcp request");
   end
   if (int'(MBAP_LEN) + 8 > 16) begin : g_ans_chk
      $error("answer buffer shorter than the longest answer");
   end

   // one crc16 byte step, reflected
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0]  b);
      logic [15:0] v;
      v = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
      end
      return v;
   endfunction : crc_step

   // crc16 over the first n bytes of an answer
   function automatic logic [15:0] crc_over(input logic [15:0][7:0] b,
                                            input logic [3:0]        n);
      logic [15:0] v;
      v = CRC_INIT;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n) begin
            v = crc_step(v, b[i]);
         end
      end
      return v;
   endfunction : crc_over

   // status word as served at the condition register
   logic [31:0] condition_word;
   always_comb begin
      condition_word = '0;
      condition_word[LOC_LSB +: 5] = r.remote ? LOC_REMOTE_SELF
                                              : LOC_LOCAL;
      condition_word[OUT_ON_BIT] = output_on;
      condition_word[REG_MODE_LSB +: 2] = current_regulation_mode;
   end

   // request fields from the buffered core
   logic [7:0]  fc;
   logic [15:0] addr;
   logic [15:0] val;
   logic [15:0] rx_crc;
   logic        inhibit;
   always_comb begin
      fc     = r.rxb[1];
      addr   = {r.rxb[2], r.rxb[3]};
      val    = {r.rxb[4], r.rxb[5]};
      rx_crc = {r.rxb[7], r.rxb[6]};
      inhibit = cond.local_lockout | cond.other_iface_remote
              | cond.setup_menu_open | cond.power_off;
   end

   // frame receive, decode and answer sequencing
   always_comb begin
      logic [7:0]  exc;
      logic [31:0] word;
      logic [3:0]  n;
      logic [15:0] c;
      logic        ok;

      exc  = '0;
      word = '0;
      n    = '0;
      c    = CRC_INIT;
      ok   = 1'b0;
      next_r = r;
      next_r.disp = 1'b0;
      // lockout and power loss end remote whatever the state
      if (cond.local_lockout || cond.power_off) begin
         next_r.remote = 1'b0;
      end
      case (r.st)
         MBRC_IDLE: begin
            next_r.tx = '0;
            if (rx.valid) begin
               next_r.tcp  = tcp_mode;
               next_r.drop = tcp_mode && (tcp_port != TCP_PORT);
               next_r.cnt  = 4'd1;
               next_r.crc  = crc_step(CRC_INIT, rx.data);
               next_r.rxb  = '0;
               next_r.tid  = '0;
               if (tcp_mode) begin
                  next_r.tid[15:8] = rx.data;
               end else begin
                  next_r.rxb[0] = rx.data;
               end
               next_r.st = rx.last ? MBRC_IDLE : MBRC_RECV;
            end
         end

         MBRC_RECV: begin
            if (rx.valid) begin
               next_r.cnt = r.cnt + 4'd1;
               if (r.tcp) begin
                  if (r.cnt == 4'd1) begin
                     next_r.tid[7:0] = rx.data;
                  end
                  if (r.cnt >= MBAP_LEN) begin
                     next_r.rxb[3'(r.cnt - MBAP_LEN)] = rx.data;
                  end
                  if (r.cnt == 4'd2 || r.cnt == 4'd3) begin
                     if (rx.data != 8'h00) begin
                        next_r.drop = 1'b1;
                     end
                  end
                  // length field must announce the six request bytes
                  if (r.cnt == 4'd4 && rx.data != 8'h00) begin
                     next_r.drop = 1'b1;
                  end
                  if (r.cnt == 4'd5 && rx.data != {4'h0, PDU_REQ_LEN}) begin
                     next_r.drop = 1'b1;
                  end
                  if (r.cnt >= MBAP_LEN + PDU_REQ_LEN) begin
                     next_r.drop = 1'b1;
                  end
               end else begin
                  next_r.rxb[3'(r.cnt)] = rx.data;
                  // crc runs over every byte ahead of the trailer
                  if (r.cnt < 4'd6) begin
                     next_r.crc = crc_step(r.crc, rx.data);
                  end
                  if (r.cnt >= RTU_REQ_LEN) begin
                     next_r.drop = 1'b1;
                  end
               end
               if (rx.last) begin
                  next_r.st = MBRC_EXEC;
               end
            end
         end

         MBRC_EXEC: begin
            next_r.st = MBRC_IDLE;
            if (!r.drop && r.rxb[0] == SLAVE_ID) begin
               next_r.st = MBRC_SEND;
               // short or long rtu frames stay unanswered
               if (!r.tcp && (r.cnt != RTU_REQ_LEN)) begin
                  next_r.st = MBRC_IDLE;
               end else if (!r.tcp && (rx_crc != r.crc)) begin
                  exc = EXC_CRC;
               end else if (r.tcp && (r.cnt != MBAP_LEN + PDU_REQ_LEN)) begin
                  exc = EXC_BAD_DATA;
               end else if (fc == FC_READ_HOLD) begin
                  if (addr == REG_RATED_VOLT) begin
                     word = rated_voltage_float;
                  end else if (addr == REG_CONDITION) begin
                     word = condition_word;
                  end else begin
                     exc = EXC_BAD_ADDR;
                  end
                  if (exc == 8'h00 && val != READ_COUNT) begin
                     exc = EXC_BAD_DATA;
                  end
               end else if (fc == FC_WRITE_COIL) begin
                  if (addr != COIL_REMOTE) begin
                     exc = EXC_BAD_ADDR;
                  end else if (val == COIL_ON) begin
                     if (!cond.allow_remote) begin
                        exc = EXC_LOCAL;
                     end else if (inhibit) begin
                        exc = EXC_DENIED;
                     end else begin
                        ok = 1'b1;
                        next_r.remote = 1'b1;
                        next_r.disp   = 1'b1;
                     end
                  end else if (val == COIL_OFF) begin
                     if (cond.other_iface_remote) begin
                        exc = EXC_DENIED;
                     end else begin
                        ok = 1'b1;
                        next_r.disp = r.remote;
                        next_r.remote = 1'b0;
                     end
                  end else begin
                     exc = EXC_BAD_DATA;
                  end
               end else begin
                  exc = EXC_BAD_FC;
               end

               // build answer core: addr fc ...
               next_r.txb = '0;
               next_r.txb[0] = r.rxb[0];
               if (exc != 8'h00) begin
                  next_r.txb[1] = fc | FC_EXC_FLAG;
                  next_r.txb[2] = exc;
                  n = 4'd3;
               end else if (ok) begin
                  for (int i = 1; i < 6; i++) begin
                     next_r.txb[i] = r.rxb[i];
                  end
                  n = 4'd6;
               end else begin
                  next_r.txb[1] = fc;
                  next_r.txb[2] = READ_BYTES;
                  next_r.txb[3] = word[31:24];
                  next_r.txb[4] = word[23:16];
                  next_r.txb[5] = word[15:8];
                  next_r.txb[6] = word[7:0];
                  n = 4'd7;
               end

               if (r.tcp) begin
                  // shift core behind header, no crc
                  for (int i = 15; i >= 6; i--) begin
                     next_r.txb[i] = next_r.txb[i - 6];
                  end
                  next_r.txb[0] = r.tid[15:8];
                  next_r.txb[1] = r.tid[7:0];
                  next_r.txb[2] = PROTO_ID[15:8];
                  next_r.txb[3] = PROTO_ID[7:0];
                  next_r.txb[4] = 8'h00;
                  next_r.txb[5] = {4'h0, n};
                  next_r.len = n + MBAP_LEN;
               end else begin
                  c = crc_over(next_r.txb, n);
                  next_r.txb[n]        = c[7:0];
                  next_r.txb[n + 4'd1] = c[15:8];
                  next_r.len = n + 4'd2;
               end
               next_r.idx = '0;
            end
         end

         MBRC_SEND: begin
            // a byte stands until taken; taking the last ends the answer
            if (!r.tx.valid || tx_ready) begin
               if (r.tx.valid && r.tx.last) begin
                  next_r.tx = '0;
                  next_r.st = MBRC_IDLE;
               end else begin
                  next_r.tx.valid = 1'b1;
                  next_r.tx.data  = r.txb[r.idx];
                  next_r.tx.last  = (r.idx == r.len - 4'd1);
                  next_r.idx      = r.idx + 4'd1;
               end
            end
         end
         default: next_r.st = MBRC_IDLE;
      endcase
   end

   // synchronous reset back to idle with a fresh crc
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= MBRC_IDLE;
         r.crc <= CRC_INIT;
      end else begin
         r <= next_r;
      end
   end

   assign tx             = r.tx;
   assign remote_active  = r.remote;
   assign display_update = r.disp;
endmodule : mbrc_slave

//--- tb/mbrc_slave_asserts.sv
// port assertions for the modbus remote control slave
`timescale 1ns/1ps
module mbrc_slave_asserts
   import mbrc_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // streams, conditions and remote state
   input wire mbrc_byte_t rx,
   input wire logic       tx_ready,
   input wire mbrc_byte_t tx,
   input wire mbrc_cond_t cond,
   input wire logic       remote_active,
   input wire logic       display_update
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_answer_lag: assert property (
      $rose(tx.valid) |-> $past(rx.valid && rx.last, 3))
      else $error("answer lag");
   a_tx_hold: assert property (
      tx.valid && !tx_ready |=> tx.valid && $stable(tx))
      else $error("tx hold");
   a_disp_pulse: assert property (
      display_update |=> !display_update) else $error("pulse");
   a_disp_cause: assert property (
      display_update == ($changed(remote_active)
      && $past(rx.valid && rx.last, 2))) else $error("display");
   a_self_grant: assert property (
      $rose(remote_active) |-> $past(rx.valid && rx.last, 2))
      else $error("grant");
   a_allow_req: assert property (
      $rose(remote_active) |-> $past(cond.allow_remote, 1))
      else $error("allow");
   a_busy_block: assert property (
      $rose(remote_active) |-> !$past(cond.other_iface_remote
      || cond.setup_menu_open, 1)) else $error("busy");
   a_lock_clear: assert property (
      cond.local_lockout |=> !remote_active) else $error("lockout");
   a_power_clear: assert property (
      cond.power_off |=> !remote_active) else $error("power");
endmodule : mbrc_slave_asserts
bind mbrc_slave mbrc_slave_asserts u_chk (.clk, .rst_n, .rx, .tx_ready,
   .tx, .cond, .remote_active, .display_update);

//--- tb/mbrc_host.sv
// modbus master model on the host side of the slave
`timescale 1ns/1ps
module mbrc_host
   import mbrc_pkg::*;
(
   // clock
   input  wire logic       clk,
   // request side
   output mbrc_byte_t      rx,
   output logic            tcp_mode,
   output logic [15:0]     tcp_port,
   // answer side
   output logic            tx_ready,
   input  wire mbrc_byte_t tx
);
   typedef logic [7:0] mbrc_bq_t[$];
   initial begin
      rx = '0;
      tcp_mode = 1'b0;
      tcp_port = 16'd502;
      tx_ready = 1'b0;
   end
   function automatic logic [15:0] crc16(input mbrc_bq_t q);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction : crc16
   function automatic mbrc_bq_t wrap(input mbrc_bq_t c, input logic t,
                                     input logic [15:0] id);
      logic [15:0] r;
      if (c.size() == 0) return c;
      r = t ? 16'(c.size()) : crc16(c);
      if (t) return {id[15:8], id[7:0], 8'h00, 8'h00,
                     r[15:8], r[7:0], c};
      return {c, r[7:0], r[15:8]};
   endfunction : wrap
   // bad swaps the checksum bytes into the wrong order
   task automatic xfer(input mbrc_bq_t f, input logic t,
                       input logic [15:0] port, id, input bit slow, bad,
                       output mbrc_bq_t got);
      mbrc_bq_t w;
      w = wrap(f, t, id);
      if (bad) w = {w[0:$-2], w[$], w[$-1]};
      got = {};
      tcp_mode = t;
      tcp_port = port;
      foreach (w[i]) begin
         @(negedge clk);
         rx = '{1'b1, i == w.size() - 1, w[i]};
      end
      @(negedge clk);
      rx = '{1'b0, 1'b0, ~rx.data};
      for (int n = 0; n < 60; n++) begin
         @(negedge clk);
         tx_ready = slow ? !tx_ready : 1'b1;
         if (tx.valid && tx_ready) got.push_back(tx.data);
         if (tx.valid && tx_ready && tx.last) break;
      end
   endtask : xfer
endmodule : mbrc_host

//--- tb/mbrc_slave_test.sv
// self-checking bench for the modbus remote control slave
`timescale 1ns/1ps
module mbrc_slave_test
   import mbrc_pkg::*;
;
   typedef logic [7:0] mbrc_bq_t[$];
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        tcp_mode;
   logic        tx_ready;
   logic [15:0] tcp_port;
   logic [31:0] volt = 32'h42a00000;
   logic        output_on = 1'b1;
   logic [1:0]  mode = 2'b10;
   mbrc_cond_t  cond = 5'b10000;
   mbrc_byte_t  rx;
   mbrc_byte_t  tx;
   logic        remote_active;
   logic        display_update;
   mbrc_bq_t    none;
   int          miscompares = 0;
   int          n_checks = 0;
   always #20 clk = ~clk;
   mbrc_slave dut (.clk, .rst_n, .rx, .tcp_mode, .tcp_port, .tx_ready, .tx,
      .rated_voltage_float(volt), .output_on,
      .current_regulation_mode(mode), .cond, .remote_active,
      .display_update);
   mbrc_host host (.clk, .rx, .tcp_mode, .tcp_port, .tx_ready, .tx);
   function automatic mbrc_bq_t rd(input logic [15:0] a);
      return {8'h00, 8'h03, a[15:8], a[7:0], 8'h00, 8'h02};
   endfunction : rd
   function automatic mbrc_bq_t rsp(input logic [31:0] w);
      return {8'h00, 8'h03, 8'h04, w[31:24], w[23:16], w[15:8], w[7:0]};
   endfunction : rsp
   function automatic mbrc_bq_t coil(input logic [15:0] v);
      return {8'h00, 8'h05, 8'h01, 8'h92, v[15:8], v[7:0]};
   endfunction : coil
   function automatic mbrc_bq_t pdu(input logic [7:0] id, f,
                                    input logic [15:0] a, n);
      return {id, f, a[15:8], a[7:0], n[15:8], n[7:0]};
   endfunction : pdu
   function automatic mbrc_bq_t exc(input logic [7:0] f, e);
      return {8'h00, f + 8'h80, e};
   endfunction : exc
   task automatic cmp(input mbrc_bq_t got, exp);
      n_checks++;
      if (got.size() != exp.size()) begin
         miscompares++;
         $display("FAIL t=%0t len %h exp %h", $time, got.size(), exp.size());
         return;
      end
      foreach (exp[i]) if (got[i] !== exp[i]) begin
         miscompares++;
         $display("FAIL t=%0t got %h exp %h", $time, got[i], exp[i]);
         return;
      end
   endtask : cmp
   task automatic flag(input logic exp);
      n_checks++;
      if (remote_active !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got %h exp %h", $time, remote_active, exp);
      end
   endtask : flag
   task automatic run(input mbrc_bq_t q, exp, input logic t = 1'b0,
                      input logic [15:0] id = 16'h0000, port = 16'd502,
                      input bit slow = 1'b0, bad = 1'b0);
      mbrc_bq_t got;
      host.xfer(q, t, port, id, slow, bad, got);
      cmp(got, host.wrap(exp, t, id));
   endtask : run
   task automatic t_reads;
      run(rd(16'h0079), rsp(volt), .slow(1'b1));
      run(rd(16'h01f9), rsp({21'h0, mode, 1'b0, output_on, 7'h00}));
      run(rd(16'h0079), exc(8'h03, 8'h05), .bad(1'b1));
      $display("reads done");
   endtask : t_reads
   task automatic t_errors;
      run(pdu(8'h00, 8'h04, 16'h0079, 16'h0002), exc(8'h04, 8'h01));
      run(rd(16'h0080), exc(8'h03, 8'h02));
      run(pdu(8'h00, 8'h03, 16'h0079, 16'h0001), exc(8'h03, 8'h03));
      run(coil(16'h1234), exc(8'h05, 8'h03));
      flag(1'b0);
      run(pdu(8'h01, 8'h03, 16'h0079, 16'h0002), none);
      output_on = 1'b0;
      mode      = 2'b01;
      run(rd(16'h01f9), rsp(32'h00000200));
      output_on = 1'b1;
      mode      = 2'b10;
      $display("errors done");
   endtask : t_errors
   task automatic t_refuse;
      mbrc_cond_t c[5] = '{5'b00000, 5'b11000, 5'b10100, 5'b10010, 5'b10001};
      logic [7:0] e[5] = '{8'h17, 8'h07, 8'h07, 8'h07, 8'h07};
      for (int i = 0; i < 5; i++) begin
         cond = c[i];
         run(coil(16'hff00), exc(8'h05, e[i]));
         flag(1'b0);
      end
      cond = 5'b10100;
      run(coil(16'h0000), exc(8'h05, 8'h07));
      cond = 5'b10000;
      $display("refusals done");
   endtask : t_refuse
   task automatic t_remote;
      run(coil(16'hff00), coil(16'hff00));
      flag(1'b1);
      run(rd(16'h01f9), rsp(32'h00000483));
      run(coil(16'h0000), coil(16'h0000));
      flag(1'b0);
      run(coil(16'hff00), coil(16'hff00), 1'b1, 16'h1234);
      cond.local_lockout = 1'b1;
      @(negedge clk);
      flag(1'b0);
      cond = 5'b10000;
      run(coil(16'hff00), coil(16'hff00));
      repeat (20) @(negedge clk);
      flag(1'b1);
      cond.power_off = 1'b1;
      @(negedge clk);
      flag(1'b0);
      cond = 5'b10000;
      $display("remote done");
   endtask : t_remote
   task automatic t_tcp;
      run(rd(16'h0079), rsp(volt), 1'b1, 16'h4711, .slow(1'b1));
      run(rd(16'h0079), rsp(volt), 1'b1, 16'hffff);
      run(rd(16'h0079), none, 1'b1, 16'h0001, 16'd503);
      $display("tcp done");
   endtask : t_tcp
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      t_reads;
      t_errors;
      t_refuse;
      t_remote;
      t_tcp;
      close_out;
   end
   initial begin
      #400000;
      miscompares++;
      close_out;
   end
endmodule : mbrc_slave_test
